// ==== srfm_regfile.sv ====
// system register file: accumulators, prefix, pointers, counters and system control
//
// Function
// - every register read completes in one cycle, data the next cycle
// - writes to indices 00h..07h commit in one cycle
// - writes to indices 08h..0Fh commit after two cycles
// - registers are eight bits wide except the sixteen-bit ones, the five-bit flags and the four-bit stack pointer
// - swapped view returns low byte on top, high byte below
// - sign-extended view returns low byte with bit 7 copied upward
// - pointer control holds word/byte select 4:2, source select 1:0
// - clock control fields sit at bits 6..0, bit 7 reserved
// - watchdog control holds its eight flag and enable bits 7..0
`timescale 1ns/1ps
`default_nettype none

module srfm_regfile (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic [srfm_pkg::MOD_W-1:0]  reg_module,
	input  wire logic [srfm_pkg::IDX_W-1:0]  reg_index,
	input  wire logic [srfm_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [srfm_pkg::DATA_W-1:0] reg_rdata,
	output logic                          reg_wr_done,
	input  wire logic [srfm_pkg::BYTE_W-1:0] interrupt_pending_in,
	input  wire logic [srfm_pkg::DATA_W-1:0] frame_rdata_in,
	output logic      [srfm_pkg::DATA_W-1:0] frame_address,
	output logic      [srfm_pkg::DATA_W-1:0] frame_wdata,
	output logic                          frame_wr,
	output logic      [srfm_pkg::BYTE_W-1:0] clock_control_out,
	output logic      [srfm_pkg::BYTE_W-1:0] watchdog_control_out,
	output logic      [srfm_pkg::DATA_W-1:0] pointer_control_out,
	output logic      [srfm_pkg::DATA_W-1:0] active_accumulator_out,
	output logic      [srfm_pkg::DATA_W-1:0] instruction_pointer_out
);
	import srfm_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [3:0] m, input logic [3:0] i,
		input logic [3:0] tm, input logic [3:0] ti);
		hit = (m == tm) && (i == ti);
	endfunction

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] mask);
		merge8 = (old & ~mask) | (nw & mask);
	endfunction

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] acc_reg [NUM_ACC];
	logic [DATA_W-1:0] pfx_reg [NUM_PFX];
	logic [7:0]        acc_sel_reg;
	logic [7:0]        acc_ctl_reg;
	logic [FLAGS_W-1:0] flags_reg;
	logic [7:0]        int_ctl_reg;
	logic [7:0]        int_mask_reg;
	logic [7:0]        sys_ctl_reg;
	logic [7:0]        clk_ctl_reg;
	logic [7:0]        wdog_ctl_reg;
	logic [DATA_W-1:0] ip_reg;
	logic [SP_W-1:0]   sp_reg;
	logic [DATA_W-1:0] iv_reg;
	logic [DATA_W-1:0] lc0_reg;
	logic [DATA_W-1:0] lc1_reg;
	logic [7:0]        disp_reg;
	logic [DATA_W-1:0] ptr_ctl_reg;
	logic [DATA_W-1:0] gen_reg;
	logic [DATA_W-1:0] base_reg;
	logic [DATA_W-1:0] dp0_reg;
	logic [DATA_W-1:0] dp1_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rd_next;
	logic [DATA_W-1:0] frame_wdata_reg;
	logic              frame_wr_reg;

	// ------------------------------------------------------------
	// write pipeline
	// ------------------------------------------------------------
	// upper-half writes wait one extra cycle in a single holding stage;
	// the master is never stalled, so a holding write and a fresh
	// lower-half write may commit on the same edge (older first)
	logic              pend_valid_reg;
	logic [3:0]        pend_module_reg;
	logic [3:0]        pend_index_reg;
	logic [DATA_W-1:0] pend_data_reg;
	logic              wr_upper;
	logic              cv [2];
	logic [3:0]        cm [2];
	logic [3:0]        ci [2];
	logic [DATA_W-1:0] cd [2];

	assign wr_upper = reg_index[IDX_UPPER_BIT];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_valid_reg  <= 1'b0;
			pend_module_reg <= '0;
			pend_index_reg  <= '0;
			pend_data_reg   <= '0;
		end else begin
			pend_valid_reg <= reg_wr && wr_upper;
			if (reg_wr && wr_upper) begin
				pend_module_reg <= reg_module;
				pend_index_reg  <= reg_index;
				pend_data_reg   <= reg_wdata;
			end
		end
	end

	assign cv[0] = pend_valid_reg;
	assign cm[0] = pend_module_reg;
	assign ci[0] = pend_index_reg;
	assign cd[0] = pend_data_reg;
	assign cv[1] = reg_wr && !wr_upper;
	assign cm[1] = reg_module;
	assign ci[1] = reg_index;
	assign cd[1] = reg_wdata;

	assign reg_wr_done = cv[0] || cv[1];

	// ------------------------------------------------------------
	// accumulator and prefix arrays
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int n = 0; n < NUM_ACC; n++) begin
				acc_reg[n] <= '0;
			end
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (cv[k] && cm[k] == MOD_ACC) begin
					acc_reg[ci[k]] <= cd[k];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int n = 0; n < NUM_PFX; n++) begin
				pfx_reg[n] <= '0;
			end
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (cv[k] && cm[k] == MOD_PFX && !ci[k][IDX_UPPER_BIT]) begin
					pfx_reg[ci[k][2:0]] <= cd[k];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// system control group
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_sel_reg  <= '0;
			acc_ctl_reg  <= '0;
			flags_reg    <= '0;
			int_ctl_reg  <= '0;
			int_mask_reg <= '0;
			sys_ctl_reg  <= SYS_CTL_RST;
			clk_ctl_reg  <= CLK_CTL_RST;
			wdog_ctl_reg <= WDOG_CTL_RST;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_ACC_SEL)) begin
					acc_sel_reg <= merge8(acc_sel_reg, cd[k][7:0], ACC_SEL_WMASK);
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_ACC_SEL_CTL)) begin
					acc_ctl_reg <= merge8(acc_ctl_reg, cd[k][7:0], ACC_CTL_WMASK);
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_PROC_FLAGS)) begin
					flags_reg <= cd[k][FLAGS_W-1:0];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_INT_CTL)) begin
					int_ctl_reg <= merge8(int_ctl_reg, cd[k][7:0], INT_CTL_WMASK);
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_INT_MASK)) begin
					int_mask_reg <= merge8(int_mask_reg, cd[k][7:0], INT_MASK_WMASK);
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_SYS_CTL)) begin
					sys_ctl_reg <= merge8(sys_ctl_reg, cd[k][7:0], SYS_CTL_WMASK);
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_CLK_CTL)) begin
					clk_ctl_reg <= merge8(clk_ctl_reg, cd[k][7:0], CLK_CTL_WMASK);
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SYS, IDX_WDOG_CTL)) begin
					wdog_ctl_reg <= merge8(wdog_ctl_reg, cd[k][7:0], WDOG_CTL_WMASK);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// instruction pointer, stack, vector and loop counters
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ip_reg  <= INSTR_PTR_RST;
			sp_reg  <= STACK_PTR_RST;
			iv_reg  <= '0;
			lc0_reg <= '0;
			lc1_reg <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (cv[k] && hit(cm[k], ci[k], MOD_IP, IDX_INSTR_PTR)) begin
					ip_reg <= cd[k];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SP, IDX_STACK_PTR)) begin
					sp_reg <= cd[k][SP_W-1:0];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SP, IDX_INT_VECTOR)) begin
					iv_reg <= cd[k];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SP, IDX_LOOP_CNT0)) begin
					lc0_reg <= cd[k];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_SP, IDX_LOOP_CNT1)) begin
					lc1_reg <= cd[k];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pointer control, general register and frame pointer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			disp_reg    <= '0;
			ptr_ctl_reg <= PTR_CTL_RST;
			gen_reg     <= '0;
			base_reg    <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (cv[k] && hit(cm[k], ci[k], MOD_DPC, IDX_FRAME_DISP)) begin
					disp_reg <= cd[k][7:0];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_DPC, IDX_PTR_CTL)) begin
					ptr_ctl_reg <= cd[k] & PTR_CTL_WMASK;
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_DPC, IDX_GEN)) begin
					gen_reg <= cd[k];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_DPC, IDX_GEN_LOW)) begin
					gen_reg[7:0] <= cd[k][7:0];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_DPC, IDX_GEN_HIGH)) begin
					gen_reg[15:8] <= cd[k][7:0];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_DPC, IDX_FRAME_BASE)) begin
					base_reg <= cd[k];
				end
			end
		end
	end

	// frame-indexed writes go out to data memory; the swapped and
	// sign-extended views are read-only, so writes to them drop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_wr_reg    <= 1'b0;
			frame_wdata_reg <= '0;
		end else begin
			frame_wr_reg <= cv[0] && hit(cm[0], ci[0], MOD_DPC, IDX_FRAME_ACCESS);
			if (cv[0] && hit(cm[0], ci[0], MOD_DPC, IDX_FRAME_ACCESS)) begin
				frame_wdata_reg <= cd[0];
			end
		end
	end

	// ------------------------------------------------------------
	// data pointers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dp0_reg <= '0;
			dp1_reg <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (cv[k] && hit(cm[k], ci[k], MOD_DP, IDX_DATA_PTR0)) begin
					dp0_reg <= cd[k];
				end
				if (cv[k] && hit(cm[k], ci[k], MOD_DP, IDX_DATA_PTR1)) begin
					dp1_reg <= cd[k];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [DATA_W-1:0] active_acc;
	logic [7:0]        flags_view;

	assign active_acc = acc_reg[acc_sel_reg[3:0]];

	always_comb begin
		flags_view = {3'h0, flags_reg};
		flags_view[FLAG_ZERO_BIT] = (active_acc == '0);
		flags_view[FLAG_SIGN_BIT] = active_acc[DATA_W-1];
	end

	// a read sees the committed state; an upper-half write still in
	// the holding stage is not yet visible
	always_comb begin
		rd_next = '0;
		case (reg_module)
			MOD_SYS: begin
				case (reg_index)
					IDX_ACC_SEL:     rd_next = {8'h00, acc_sel_reg};
					IDX_ACC_SEL_CTL: rd_next = {8'h00, acc_ctl_reg};
					IDX_PROC_FLAGS:  rd_next = {8'h00, flags_view};
					IDX_INT_CTL:     rd_next = {8'h00, int_ctl_reg};
					IDX_INT_MASK:    rd_next = {8'h00, int_mask_reg};
					IDX_SYS_CTL:     rd_next = {8'h00, sys_ctl_reg};
					IDX_INT_PEND:    rd_next = {8'h00, interrupt_pending_in & INT_MASK_WMASK};
					IDX_CLK_CTL:     rd_next = {8'h00, clk_ctl_reg | CLK_CTL_FIXED};
					IDX_WDOG_CTL:    rd_next = {8'h00, wdog_ctl_reg};
					default:         rd_next = '0;
				endcase
			end
			MOD_ACC: rd_next = acc_reg[reg_index];
			MOD_PFX: begin
				if (!reg_index[IDX_UPPER_BIT]) begin
					rd_next = pfx_reg[reg_index[2:0]];
				end
			end
			MOD_IP: begin
				if (reg_index == IDX_INSTR_PTR) begin
					rd_next = ip_reg;
				end
			end
			MOD_SP: begin
				case (reg_index)
					IDX_STACK_PTR:  rd_next = {12'h000, sp_reg};
					IDX_INT_VECTOR: rd_next = iv_reg;
					IDX_LOOP_CNT0:  rd_next = lc0_reg;
					IDX_LOOP_CNT1:  rd_next = lc1_reg;
					default:        rd_next = '0;
				endcase
			end
			MOD_DPC: begin
				case (reg_index)
					IDX_FRAME_DISP:   rd_next = {8'h00, disp_reg};
					IDX_PTR_CTL:      rd_next = ptr_ctl_reg;
					IDX_GEN:          rd_next = gen_reg;
					IDX_GEN_LOW:      rd_next = {8'h00, gen_reg[7:0]};
					IDX_FRAME_BASE:   rd_next = base_reg;
					IDX_GEN_SWAP:     rd_next = {gen_reg[7:0], gen_reg[15:8]};
					IDX_GEN_HIGH:     rd_next = {8'h00, gen_reg[15:8]};
					IDX_GEN_SEXT:     rd_next = {{8{gen_reg[7]}}, gen_reg[7:0]};
					IDX_FRAME_ACCESS: rd_next = frame_rdata_in;
					default:          rd_next = '0;
				endcase
			end
			MOD_DP: begin
				case (reg_index)
					IDX_DATA_PTR0: rd_next = dp0_reg;
					IDX_DATA_PTR1: rd_next = dp1_reg;
					default:       rd_next = '0;
				endcase
			end
			default: rd_next = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= reg_rd ? rd_next : '0;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata               = rdata_reg;
	assign frame_address           = base_reg + {8'h00, disp_reg};
	assign frame_wdata             = frame_wdata_reg;
	assign frame_wr                = frame_wr_reg;
	assign clock_control_out       = clk_ctl_reg | CLK_CTL_FIXED;
	assign watchdog_control_out    = wdog_ctl_reg;
	assign pointer_control_out     = ptr_ctl_reg;
	assign active_accumulator_out  = active_acc;
	assign instruction_pointer_out = ip_reg;

endmodule

`default_nettype wire

// ==== srfm_pkg.sv ====
// shared constants for the processor system register file
package srfm_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int MOD_W   = 4;
	localparam int IDX_W   = 4;
	localparam int DATA_W  = 16;
	localparam int BYTE_W  = 8;
	localparam int NUM_ACC = 16;
	localparam int NUM_PFX = 8;
	localparam int SP_W    = 4;

	// ------------------------------------------------------------
	// module numbers
	// ------------------------------------------------------------
	localparam logic [3:0] MOD_SYS = 4'h8;
	localparam logic [3:0] MOD_ACC = 4'h9;
	localparam logic [3:0] MOD_PFX = 4'hB;
	localparam logic [3:0] MOD_IP  = 4'hC;
	localparam logic [3:0] MOD_SP  = 4'hD;
	localparam logic [3:0] MOD_DPC = 4'hE;
	localparam logic [3:0] MOD_DP  = 4'hF;

	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_ACC_SEL      = 4'h0;
	localparam logic [3:0] IDX_ACC_SEL_CTL  = 4'h1;
	localparam logic [3:0] IDX_PROC_FLAGS   = 4'h4;
	localparam logic [3:0] IDX_INT_CTL      = 4'h5;
	localparam logic [3:0] IDX_INT_MASK     = 4'h6;
	localparam logic [3:0] IDX_SYS_CTL      = 4'h8;
	localparam logic [3:0] IDX_INT_PEND     = 4'hB;
	localparam logic [3:0] IDX_CLK_CTL      = 4'hE;
	localparam logic [3:0] IDX_WDOG_CTL     = 4'hF;
	localparam logic [3:0] IDX_INSTR_PTR    = 4'h0;
	localparam logic [3:0] IDX_STACK_PTR    = 4'h1;
	localparam logic [3:0] IDX_INT_VECTOR   = 4'h2;
	localparam logic [3:0] IDX_LOOP_CNT0    = 4'h6;
	localparam logic [3:0] IDX_LOOP_CNT1    = 4'h7;
	localparam logic [3:0] IDX_FRAME_DISP   = 4'h3;
	localparam logic [3:0] IDX_PTR_CTL      = 4'h4;
	localparam logic [3:0] IDX_GEN          = 4'h5;
	localparam logic [3:0] IDX_GEN_LOW      = 4'h6;
	localparam logic [3:0] IDX_FRAME_BASE   = 4'h7;
	localparam logic [3:0] IDX_GEN_SWAP     = 4'h8;
	localparam logic [3:0] IDX_GEN_HIGH     = 4'h9;
	localparam logic [3:0] IDX_GEN_SEXT     = 4'hA;
	localparam logic [3:0] IDX_FRAME_ACCESS = 4'hB;
	localparam logic [3:0] IDX_DATA_PTR0    = 4'h3;
	localparam logic [3:0] IDX_DATA_PTR1    = 4'h7;
	localparam int         IDX_UPPER_BIT    = 3;

	// ------------------------------------------------------------
	// writable masks, fixed bits and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  ACC_SEL_WMASK   = 8'h0F;
	localparam logic [7:0]  ACC_CTL_WMASK   = 8'hC7;
	localparam logic [7:0]  INT_CTL_WMASK   = 8'h03;
	localparam logic [7:0]  INT_MASK_WMASK  = 8'h8F;
	localparam logic [7:0]  SYS_CTL_WMASK   = 8'h92;
	localparam logic [7:0]  CLK_CTL_WMASK   = 8'h7F;
	localparam logic [7:0]  CLK_CTL_FIXED   = 8'h80;
	localparam logic [7:0]  WDOG_CTL_WMASK  = 8'hFF;
	localparam logic [15:0] PTR_CTL_WMASK   = 16'h001F;
	localparam int          FLAGS_W         = 5;
	localparam int          FLAG_ZERO_BIT   = 7;
	localparam int          FLAG_SIGN_BIT   = 6;

	localparam logic [7:0]  SYS_CTL_RST     = 8'h82;
	localparam logic [7:0]  CLK_CTL_RST     = 8'h00;
	localparam logic [7:0]  WDOG_CTL_RST    = 8'h00;
	localparam logic [15:0] INSTR_PTR_RST   = 16'h8000;
	localparam logic [3:0]  STACK_PTR_RST   = 4'hF;
	localparam logic [15:0] PTR_CTL_RST     = 16'h001C;

	// pointer control fields
	localparam int WBS_LSB  = 2;
	localparam int WBS_MSB  = 4;
	localparam int SDPS_LSB = 0;
	localparam int SDPS_MSB = 1;

endpackage

// ==== srfm_regfile_chk.sv ====
// assertion checker for the system register file ports
`timescale 1ns/1ps
`default_nettype none

module srfm_regfile_chk (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [3:0]  reg_module,
	input wire logic [3:0]  reg_index,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_wr_done,
	input wire logic [7:0]  interrupt_pending_in,
	input wire logic [15:0] frame_rdata_in,
	input wire logic [15:0] frame_address,
	input wire logic [15:0] frame_wdata,
	input wire logic        frame_wr,
	input wire logic [7:0]  clock_control_out,
	input wire logic [7:0]  watchdog_control_out,
	input wire logic [15:0] pointer_control_out,
	input wire logic [15:0] active_accumulator_out,
	input wire logic [15:0] instruction_pointer_out
);
	import srfm_pkg::*;

	// ------------------------------------------------------------
	// helper: an upper write waiting for its commit edge
	// ------------------------------------------------------------
	logic upper_pend_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			upper_pend_reg <= 1'b0;
		end else begin
			upper_pend_reg <= reg_wr & reg_index[3];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_lower_write_done: assert property (reg_wr && !reg_index[3] |-> reg_wr_done)
		else $error("lower write did not commit in its own cycle");
	a_upper_write_done: assert property (reg_wr && reg_index[3] |=> reg_wr_done)
		else $error("upper write did not commit one cycle later");
	a_done_has_cause: assert property (reg_wr_done |-> (reg_wr && !reg_index[3]) || upper_pend_reg)
		else $error("write commit without a matching write");
	a_clk_ctl_fixed: assert property (clock_control_out[7] == 1'b1)
		else $error("clock control reserved bit not one");
	a_ptr_ctl_reserved: assert property (pointer_control_out[15:5] == 11'h000)
		else $error("pointer control reserved bits not zero");
	a_ptr_ctl_write: assert property (reg_wr && reg_module == MOD_DPC && reg_index == IDX_PTR_CTL
		|=> pointer_control_out == ($past(reg_wdata) & 16'h001F))
		else $error("pointer control fields not written");
	a_wdog_two_cycle: assert property (reg_wr && !upper_pend_reg && reg_module == MOD_SYS && reg_index == IDX_WDOG_CTL
		|=> $stable(watchdog_control_out) ##1 {8'h00, watchdog_control_out} == ($past(reg_wdata, 2) & 16'h00FF))
		else $error("watchdog control write timing or value wrong");
	a_clk_two_cycle: assert property (reg_wr && !upper_pend_reg && reg_module == MOD_SYS && reg_index == IDX_CLK_CTL
		|=> $stable(clock_control_out) ##1 {8'h00, clock_control_out} == (($past(reg_wdata, 2) & 16'h007F) | 16'h0080))
		else $error("clock control write timing or value wrong");
	a_ip_one_cycle: assert property (reg_wr && reg_module == MOD_IP && reg_index == IDX_INSTR_PTR
		|=> instruction_pointer_out == $past(reg_wdata))
		else $error("instruction pointer not written in one cycle");
	a_frame_write: assert property (reg_wr && reg_module == MOD_DPC && reg_index == IDX_FRAME_ACCESS
		|-> ##2 (frame_wr && frame_wdata == $past(reg_wdata, 2)))
		else $error("frame write not issued two cycles after its strobe");
endmodule

bind srfm_regfile srfm_regfile_chk u_chk (
	.clk(clk), .sys_rst(sys_rst), .reg_module(reg_module), .reg_index(reg_index),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_wr_done(reg_wr_done), .interrupt_pending_in(interrupt_pending_in),
	.frame_rdata_in(frame_rdata_in), .frame_address(frame_address), .frame_wdata(frame_wdata),
	.frame_wr(frame_wr), .clock_control_out(clock_control_out),
	.watchdog_control_out(watchdog_control_out), .pointer_control_out(pointer_control_out),
	.active_accumulator_out(active_accumulator_out), .instruction_pointer_out(instruction_pointer_out)
);

`default_nettype wire

// ==== srfm_regfile_tb.sv ====
// self-checking bench for the system register file
`timescale 1ns/1ps
`default_nettype none

module srfm_regfile_tb;
	import srfm_pkg::*;

	logic        clk;
	logic        sys_rst;
	logic [3:0]  reg_module;
	logic [3:0]  reg_index;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        reg_wr_done;
	logic [7:0]  irq_pend;
	logic [15:0] frame_rdata;
	logic [7:0]  clk_ctl;
	logic [7:0]  wdog_ctl;
	logic [15:0] ptr_ctl;
	logic [15:0] ip_out;
	logic [15:0] frame_addr;
	logic [15:0] frame_wd;
	logic        frame_wr_o;
	logic [15:0] acc_out;
	int          failures;
	int          n_tests;

	srfm_regfile u_dut (
		.clk(clk), .sys_rst(sys_rst), .reg_module(reg_module), .reg_index(reg_index),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_wr_done(reg_wr_done), .interrupt_pending_in(irq_pend), .frame_rdata_in(frame_rdata),
		.frame_address(frame_addr), .frame_wdata(frame_wd), .frame_wr(frame_wr_o), .clock_control_out(clk_ctl),
		.watchdog_control_out(wdog_ctl), .pointer_control_out(ptr_ctl),
		.active_accumulator_out(acc_out), .instruction_pointer_out(ip_out)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] m, input logic [3:0] i, input logic [15:0] d);
		reg_module <= m;
		reg_index  <= i;
		reg_wdata  <= d;
		reg_wr     <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rchk(input logic [3:0] m, input logic [3:0] i, input logic [15:0] exp);
		reg_module <= m;
		reg_index  <= i;
		reg_rd     <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk($sformatf("read m%h i%h", m, i), reg_rdata, exp);
		@(posedge clk);
	endtask

	// one idle edge lets an upper write land before the read is taken
	task automatic wrd(input logic [3:0] m, input logic [3:0] i, input logic [15:0] d, input logic [15:0] exp);
		wr(m, i, d);
		@(posedge clk);
		rchk(m, i, exp);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		chk("clock control out", {8'h00, clk_ctl}, 16'h0080);
		chk("pointer control out", ptr_ctl, 16'h001C);
		chk("ip out", ip_out, 16'h8000);
		rchk(MOD_SYS, IDX_SYS_CTL, 16'h0082);
		rchk(MOD_SP, IDX_STACK_PTR, 16'h000F);
		$display("test reset done");
	endtask

	task automatic t_timing;
		wr(MOD_IP, IDX_INSTR_PTR, 16'h1234);
		rchk(MOD_IP, IDX_INSTR_PTR, 16'h1234);
		chk("ip out", ip_out, 16'h1234);
		wr(MOD_SYS, IDX_WDOG_CTL, 16'h00A5);
		rchk(MOD_SYS, IDX_WDOG_CTL, 16'h0000);
		rchk(MOD_SYS, IDX_WDOG_CTL, 16'h00A5);
		chk("watchdog out", {8'h00, wdog_ctl}, 16'h00A5);
		$display("test timing done");
	endtask

	task automatic t_views;
		wrd(MOD_DPC, IDX_GEN, 16'h3C96, 16'h3C96);
		rchk(MOD_DPC, IDX_GEN_SWAP, 16'h963C);
		rchk(MOD_DPC, IDX_GEN_SEXT, 16'hFF96);
		rchk(MOD_DPC, IDX_GEN_LOW, 16'h0096);
		rchk(MOD_DPC, IDX_GEN_HIGH, 16'h003C);
		wrd(MOD_DPC, IDX_GEN_LOW, 16'h0012, 16'h0012);
		rchk(MOD_DPC, IDX_GEN_SEXT, 16'h0012);
		wrd(MOD_DPC, IDX_GEN_HIGH, 16'h00F0, 16'h00F0);
		rchk(MOD_DPC, IDX_GEN_SWAP, 16'h12F0);
		wrd(MOD_DPC, IDX_GEN_SWAP, 16'h0000, 16'h12F0);
		rchk(MOD_DPC, IDX_GEN, 16'hF012);
		$display("test views done");
	endtask

	task automatic t_fields;
		wrd(MOD_DPC, IDX_PTR_CTL, 16'hFFFF, 16'h001F);
		chk("pointer control out", ptr_ctl, 16'h001F);
		wrd(MOD_DPC, IDX_PTR_CTL, 16'h0009, 16'h0009);
		wrd(MOD_SYS, IDX_CLK_CTL, 16'hFFFF, 16'h00FF);
		wrd(MOD_SYS, IDX_CLK_CTL, 16'h0000, 16'h0080);
		wrd(MOD_SYS, IDX_WDOG_CTL, 16'h005A, 16'h005A);
		wrd(MOD_SYS, IDX_ACC_SEL_CTL, 16'hFFFF, 16'h00C7);
		wrd(MOD_DPC, IDX_FRAME_DISP, 16'hFFFF, 16'h00FF);
		wrd(MOD_ACC, 4'hF, 16'hFFFF, 16'hFFFF);
		wrd(MOD_SP, IDX_LOOP_CNT1, 16'hA55A, 16'hA55A);
		wrd(MOD_PFX, 4'h8, 16'hFFFF, 16'h0000);
		wrd(MOD_SYS, IDX_INT_PEND, 16'h0000, 16'h008F);
		rchk(MOD_DPC, IDX_FRAME_ACCESS, 16'hBEEF);
		$display("test fields done");
	endtask

	// flags, remaining registers, frame write pulse and same-edge commits
	task automatic t_state;
		wrd(MOD_SYS, IDX_ACC_SEL, 16'h00F3, 16'h0003);
		rchk(MOD_SYS, IDX_PROC_FLAGS, 16'h0080);
		wrd(MOD_ACC, 4'h3, 16'h8001, 16'h8001);
		chk("active acc out", acc_out, 16'h8001);
		wrd(MOD_SYS, IDX_PROC_FLAGS, 16'h00FF, 16'h005F);
		wrd(MOD_SYS, IDX_SYS_CTL, 16'hFFFF, 16'h0092);
		wrd(MOD_SYS, IDX_INT_MASK, 16'hFFFF, 16'h008F);
		wrd(MOD_SP, IDX_INT_VECTOR, 16'h1357, 16'h1357);
		wrd(MOD_DP, IDX_DATA_PTR1, 16'h2468, 16'h2468);
		wrd(MOD_PFX, 4'h7, 16'h0FF0, 16'h0FF0);
		wrd(MOD_DPC, IDX_FRAME_BASE, 16'h1000, 16'h1000);
		wrd(MOD_DPC, IDX_FRAME_DISP, 16'h0020, 16'h0020);
		chk("frame address", frame_addr, 16'h1020);
		wr(MOD_DPC, IDX_FRAME_ACCESS, 16'h5A5A);
		@(negedge clk);
		chk("frame wr early", {15'h0000, frame_wr_o}, 16'h0000);
		@(negedge clk);
		chk("frame wr", {15'h0000, frame_wr_o}, 16'h0001);
		chk("frame wdata", frame_wd, 16'h5A5A);
		@(negedge clk);
		chk("frame wr end", {15'h0000, frame_wr_o}, 16'h0000);
		@(posedge clk);
		// strobe held high across two writes: upper one lands with the lower one
		reg_module <= MOD_DPC;
		reg_index  <= IDX_GEN_HIGH;
		reg_wdata  <= 16'h00AA;
		reg_wr     <= 1'b1;
		@(posedge clk);
		reg_index <= IDX_GEN;
		reg_wdata <= 16'h1234;
		@(negedge clk);
		chk("write done", {15'h0000, reg_wr_done}, 16'h0001);
		@(posedge clk);
		reg_wr <= 1'b0;
		rchk(MOD_DPC, IDX_GEN, 16'h1234);
		$display("test state done");
	endtask

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial begin
		failures    = 0;
		n_tests     = 0;
		sys_rst     = 1'b1;
		reg_module  = 4'h0;
		reg_index   = 4'h0;
		reg_wdata   = 16'h0000;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		irq_pend    = 8'hFF;
		frame_rdata = 16'hBEEF;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_timing();
		t_views();
		t_fields();
		t_state();
		final_report();
	end

	// a stuck run counts as a mismatch
	initial begin
		repeat (50000) @(posedge clk);
		failures++;
		$display("timeout reached");
		final_report();
	end
endmodule

`default_nettype wire
